// ---- rtl/ife_engine.sv ----
`timescale 1ns/10ps
`include "ife_defines.svh"

// Notes on behaviour
// - an address register write while idle and enabled starts a transfer to the seven-bit slave
// - direction one sends a read and stores returned bytes in receive fifo
// - direction zero sends a write; software feeds bytes through transmit buffer
// - busy bit reads one while in use; transmit fifo drains meanwhile
// - missing acknowledge sets sticky flag and stops; software clears it
// - receive pending while fifo holds data; clears when reads empty it
// - transmit-empty flag set when fifo empty, cleared by buffer write
// - level field shows active fifo: 00 empty, 10 half, 11 full
// - simultaneous buffer write and read sets the access clash error
// - writing a full transmit fifo sets the overfill error
// - master acknowledges each received byte but the final one by itself
// - master sends NACK on final byte once read length is reached
// - address rewrite mid-transfer ends it with repeated START
// - separate four-byte receive and transmit fifos; preload allowed
// - transmit underrun stops the write transfer
// - write error ends transfer and flushes transmit fifo
// - receive interrupt per byte or only on full fifo
// - read stops at programmed count or earlier on acknowledge error
// - interface works only when enable bit set
// - scl rate is core clock over 16 times two to the divider field
// - read length field plus one bytes are read
module ife_engine
(
    input  wire logic       core_clk,       // core clock, 200 MHz
    input  wire logic       rst,            // synchronous reset, active high
    input  wire logic       sfr_wr,         // register write strobe
    input  wire logic [7:0] sfr_waddr,      // register write address
    input  wire logic [7:0] sfr_wdata,      // register write data
    input  wire logic       sfr_rd,         // register read strobe
    input  wire logic [7:0] sfr_raddr,      // register read address
    output logic [7:0]      sfr_rdata,      // read data, next cycle
    input  wire logic       tx_irq_en,      // enable transmit-empty interrupt
    input  wire logic       rx_irq_en,      // enable receive interrupt
    input  wire logic       rx_irq_on_full, // receive interrupt only when full
    output logic            irq,            // interrupt request, level
    input  wire logic       scl_i,          // scl line level
    output logic            scl_o,          // scl drive value, always low
    output logic            scl_oe,         // scl pulled low
    input  wire logic       sda_i,          // sda line level
    output logic            sda_o,          // sda drive value, always low
    output logic            sda_oe          // sda pulled low
);
    ife_pkg::ife_core_t st;
    ife_pkg::ife_core_t next_st;
    logic       tick;
    logic       wr_mode, wr_adr, wr_stat, wr_tx, rd_rx;
    logic       tx_push, tx_pop, tx_flush, rx_push, rx_pop;
    logic [7:0] tx_dout, rx_dout;
    logic [2:0] tx_cnt, rx_cnt;
    logic       tx_full, tx_empty_f, rx_full, rx_empty_f;
    logic       receiving, last_byte, act_full, act_empty;
    logic [7:0] status;

    // =====================================================================
    // fifos and scl quarter timer
    ife_fifo u_tx_fifo (
        .core_clk (core_clk), .rst (rst), .push (tx_push), .din (sfr_wdata),
        .pop (tx_pop), .flush (tx_flush), .dout (tx_dout), .count (tx_cnt),
        .full (tx_full), .empty (tx_empty_f)
    );
    ife_fifo u_rx_fifo (
        .core_clk (core_clk), .rst (rst), .push (rx_push), .din (st.shreg),
        .pop (rx_pop), .flush (1'b0), .dout (rx_dout), .count (rx_cnt),
        .full (rx_full), .empty (rx_empty_f)
    );
    ife_tick u_tick (
        .core_clk (core_clk), .rst (rst), .run (st.state != ife_pkg::ST_IDLE),
        .div (st.mode[`IFE_MODE_DIV_HI:`IFE_MODE_DIV_LO]), .tick (tick)
    );

    // =====================================================================
    // status word
    always_comb
    begin
        receiving = st.is_read && !st.is_addr;
        last_byte = (st.rxcnt == ({1'b0, st.mode[`IFE_MODE_RCT_HI:0]} + 6'h01))
                    || st.restart_pend;
        act_full  = st.is_read ? rx_full : tx_full;
        act_empty = st.is_read ? rx_empty_f : tx_empty_f;
        status[7] = (st.state != ife_pkg::ST_IDLE) || st.start_req;
        status[6] = st.noack;
        status[5] = !rx_empty_f;
        status[4] = st.tx_empty;
        status[3:2] = act_empty ? `IFE_LVL_EMPTY :
                      (act_full ? `IFE_LVL_FULL : `IFE_LVL_HALF);
        status[1] = st.acc_err;
        status[0] = st.ovf_err;
    end

    // =====================================================================
    // register access, flags and bus sequencer
    always_comb
    begin
        next_st  = st;
        wr_mode  = sfr_wr && (sfr_waddr == `IFE_OFS_MODE);
        wr_adr   = sfr_wr && (sfr_waddr == `IFE_OFS_ADR);
        wr_stat  = sfr_wr && (sfr_waddr == `IFE_OFS_STAT);
        wr_tx    = sfr_wr && (sfr_waddr == `IFE_OFS_TX);
        rd_rx    = sfr_rd && (sfr_raddr == `IFE_OFS_RX);
        tx_push  = wr_tx;
        tx_pop   = 1'b0;
        tx_flush = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = rd_rx;
        if (wr_mode)
            next_st.mode = sfr_wdata;
        // software clears sticky flags by writing zero; sets below win
        if (wr_stat)
        begin
            next_st.noack   = st.noack && sfr_wdata[`IFE_ST_NOACK];
            next_st.acc_err = st.acc_err && sfr_wdata[`IFE_ST_ACCERR];
            next_st.ovf_err = st.ovf_err && sfr_wdata[`IFE_ST_OVFERR];
        end
        if (wr_tx && rd_rx)
            next_st.acc_err = 1'b1;
        if (wr_tx && tx_full)
            next_st.ovf_err = 1'b1;
        next_st.tx_empty = wr_tx ? 1'b0 : (tx_empty_f || st.tx_empty);
        if (sfr_rd)
        begin
            case (sfr_raddr)
                `IFE_OFS_MODE: next_st.rdata = st.mode;
                `IFE_OFS_ADR:  next_st.rdata = st.adr;
                `IFE_OFS_STAT: next_st.rdata = status;
                `IFE_OFS_RX:   next_st.rdata = rx_dout;
                default:       next_st.rdata = 8'h00;
            endcase
        end
        // address write starts a transfer, or queues a repeated start
        if (wr_adr)
        begin
            next_st.adr = sfr_wdata;
            if (st.mode[`IFE_MODE_EN])
            begin
                if (st.state == ife_pkg::ST_IDLE && !st.start_req)
                    next_st.start_req = 1'b1;
                else
                    next_st.restart_pend = 1'b1;
            end
        end
        case (st.state)
            ife_pkg::ST_IDLE:
            begin
                if (st.start_req)
                begin
                    next_st.state     = ife_pkg::ST_START;
                    next_st.q         = 2'h0;
                    next_st.start_req = 1'b0;
                end
            end
            ife_pkg::ST_START:
            begin
                if (tick)
                begin
                    next_st.q = st.q + 2'h1;
                    if (st.q == 2'h3)
                    begin
                        next_st.state        = ife_pkg::ST_SHIFT;
                        next_st.bitcnt       = 3'h7;
                        next_st.shreg        = st.adr;
                        next_st.is_addr      = 1'b1;
                        next_st.is_read      = st.adr[`IFE_ADR_DIR];
                        next_st.rxcnt        = 6'h00;
                        next_st.restart_pend = wr_adr;
                    end
                end
            end
            ife_pkg::ST_SHIFT:
            begin
                if (tick)
                begin
                    next_st.q = st.q + 2'h1;
                    if (st.q == 2'h2 && receiving)
                        next_st.shreg = {st.shreg[6:0], sda_i};
                    if (st.q == 2'h3)
                    begin
                        if (st.bitcnt != 3'h0)
                        begin
                            next_st.bitcnt = st.bitcnt - 3'h1;
                            if (!receiving)
                                next_st.shreg = {st.shreg[6:0], 1'b0};
                        end
                        else if (receiving && rx_full)
                            next_st.q = 2'h3; // hold scl high until software reads
                        else
                        begin
                            rx_push        = receiving;
                            next_st.rxcnt  = st.rxcnt + {5'h00, receiving};
                            next_st.state  = ife_pkg::ST_ACK;
                            next_st.got_nack = 1'b0;
                        end
                    end
                end
            end
            ife_pkg::ST_ACK:
            begin
                if (tick)
                begin
                    next_st.q = st.q + 2'h1;
                    if (st.q == 2'h2 && !receiving)
                        next_st.got_nack = sda_i;
                    if (st.q == 2'h3)
                    begin
                        next_st.bitcnt = 3'h7;
                        next_st.state  = ife_pkg::ST_STOP;
                        if (!receiving && st.got_nack)
                        begin
                            next_st.noack = 1'b1;
                            tx_flush      = !st.is_read;
                        end
                        else if (receiving && last_byte)
                            next_st.state = ife_pkg::ST_STOP;
                        else if (st.restart_pend)
                            next_st.state = ife_pkg::ST_RESTART;
                        else if (st.is_read)
                        begin
                            next_st.state   = ife_pkg::ST_SHIFT;
                            next_st.is_addr = 1'b0;
                        end
                        else if (!tx_empty_f)
                        begin
                            tx_pop          = 1'b1;
                            next_st.shreg   = tx_dout;
                            next_st.state   = ife_pkg::ST_SHIFT;
                            next_st.is_addr = 1'b0;
                        end
                        // an empty fifo here is an underrun and ends the write
                        if (st.restart_pend && next_st.state == ife_pkg::ST_STOP)
                            next_st.state = ife_pkg::ST_RESTART;
                    end
                end
            end
            ife_pkg::ST_STOP, ife_pkg::ST_RESTART:
            begin
                if (tick)
                begin
                    next_st.q = st.q + 2'h1;
                    if (st.q == 2'h3)
                        next_st.state = (st.state == ife_pkg::ST_RESTART || st.restart_pend) ?
                                        ife_pkg::ST_START : ife_pkg::ST_IDLE;
                end
            end
            default:
                next_st.state = ife_pkg::ST_IDLE;
        endcase
        // a disabled interface abandons any transfer and frees the bus
        if (!st.mode[`IFE_MODE_EN])
        begin
            next_st.state        = ife_pkg::ST_IDLE;
            next_st.start_req    = 1'b0;
            next_st.restart_pend = 1'b0;
        end
        // line levels for the coming quarter, pulled low only
        case (next_st.state)
            ife_pkg::ST_START:
            begin
                next_st.scl_low = 1'b0;
                next_st.sda_low = next_st.q[1];
            end
            ife_pkg::ST_SHIFT:
            begin
                next_st.scl_low = !next_st.q[1];
                next_st.sda_low = !(next_st.is_read && !next_st.is_addr) &&
                                  !next_st.shreg[7];
            end
            ife_pkg::ST_ACK:
            begin
                next_st.scl_low = !next_st.q[1];
                next_st.sda_low = next_st.is_read && !next_st.is_addr &&
                                  !(next_st.rxcnt == ({1'b0, next_st.mode[4:0]} + 6'h01)
                                    || next_st.restart_pend);
            end
            ife_pkg::ST_STOP:
            begin
                next_st.scl_low = (next_st.q == 2'h0);
                next_st.sda_low = !next_st.q[1];
            end
            ife_pkg::ST_RESTART:
            begin
                next_st.scl_low = !next_st.q[1];
                next_st.sda_low = 1'b0;
            end
            default:
            begin
                next_st.scl_low = 1'b0;
                next_st.sda_low = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st      <= '0;
            st.mode <= `IFE_RST_MODE;
            st.adr  <= `IFE_RST_ADR;
        end
        else
            st <= next_st;
    end

    // =====================================================================
    // outputs
    assign sfr_rdata = st.rdata;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = st.scl_low;
    assign sda_oe    = st.sda_low;
    assign irq = (st.tx_empty && tx_irq_en) ||
                 (rx_irq_en && (rx_irq_on_full ? rx_full : !rx_empty_f));

    // =====================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_idle_start;
        wr_adr && st.mode[`IFE_MODE_EN] && st.state == ife_pkg::ST_IDLE && !st.start_req;
    endsequence
    sequence s_start_seen;
        ##2 (st.state == ife_pkg::ST_START);
    endsequence

    a_start_on_write: assert property (s_idle_start |-> s_start_seen)
        else $error("address write did not start a transfer");
    a_noack_sticky: assert property (st.noack && !wr_stat |=> st.noack)
        else $error("missing ack flag dropped without software clear");
    a_noack_flush: assert property ($rose(st.noack) && !st.is_read |-> tx_cnt == 3'h0
        && (st.state == ife_pkg::ST_STOP || st.state == ife_pkg::ST_RESTART))
        else $error("write error did not flush and stop");
    a_rx_clear: assert property ($fell(status[5]) |-> $past(rd_rx))
        else $error("receive pending cleared without a read");
    a_tx_wr_clear: assert property (wr_tx && !tx_full |=> !st.tx_empty)
        else $error("transmit buffer write did not clear empty flag");
    a_level_code: assert property (status[3:2] != 2'h1)
        else $error("reserved fifo level code shown");
    a_clash_err: assert property (wr_tx && rd_rx |=> st.acc_err)
        else $error("access clash not flagged");
    a_overfill: assert property (wr_tx && tx_full |=> st.ovf_err && tx_cnt == 3'h4)
        else $error("overfill not flagged");
    a_rx_ack: assert property (st.state == ife_pkg::ST_ACK && receiving && !last_byte
        && !st.scl_low |-> sda_oe)
        else $error("master did not acknowledge received byte");
    a_last_nack: assert property (st.state == ife_pkg::ST_ACK && receiving && last_byte
        |-> !sda_oe)
        else $error("final byte not answered with nack");
    a_disabled_idle: assert property (!st.mode[`IFE_MODE_EN] |=> st.state == ife_pkg::ST_IDLE
        && !st.start_req)
        else $error("disabled interface is active");
endmodule

// ---- inc/ife_defines.svh ----
`ifndef IFE_DEFINES_SVH
`define IFE_DEFINES_SVH

// =====================================================================
// register addresses on the special function bus
`define IFE_OFS_TX        8'h9A
`define IFE_OFS_RX        8'h9B
`define IFE_OFS_MODE      8'hE8
`define IFE_OFS_ADR       8'hE9
`define IFE_OFS_STAT      8'hEA

// =====================================================================
// reset values
`define IFE_RST_MODE      8'h00
`define IFE_RST_ADR       8'h00

// =====================================================================
// field positions
`define IFE_MODE_EN       7
`define IFE_MODE_DIV_HI   6
`define IFE_MODE_DIV_LO   5
`define IFE_MODE_RCT_HI   4
`define IFE_ADR_DIR       0
`define IFE_ST_BUSY       7
`define IFE_ST_NOACK      6
`define IFE_ST_ACCERR     1
`define IFE_ST_OVFERR     0

// =====================================================================
// timing: one scl period is 16 << divider field, split in four quarters
`define IFE_SCL_BASE_DIV  16
`define IFE_QTR_BASE      (`IFE_SCL_BASE_DIV / 4)
`define IFE_FIFO_DEPTH    4

// fifo level codes
`define IFE_LVL_EMPTY     2'h0
`define IFE_LVL_HALF      2'h2
`define IFE_LVL_FULL      2'h3

`endif

// ---- inc/ife_pkg.sv ----
package ife_pkg;

    // =====================================================================
    // bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_START   = 3'b001,
        ST_SHIFT   = 3'b010,
        ST_ACK     = 3'b011,
        ST_STOP    = 3'b100,
        ST_RESTART = 3'b101
    } ife_state_t;

    // =====================================================================
    // whole state of the engine
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] adr;
        ife_state_t state;
        logic [1:0] q;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic       is_addr;
        logic       is_read;
        logic       start_req;
        logic       restart_pend;
        logic       got_nack;
        logic [5:0] rxcnt;
        logic       noack;
        logic       tx_empty;
        logic       acc_err;
        logic       ovf_err;
        logic       scl_low;
        logic       sda_low;
        logic [7:0] rdata;
    } ife_core_t;

    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [1:0]      wp;
        logic [1:0]      rp;
        logic [2:0]      cnt;
    } ife_fifo_t;

    typedef struct packed {
        logic [4:0] cnt;
    } ife_tick_t;

endpackage

// ---- rtl/ife_fifo.sv ----
`timescale 1ns/10ps
`include "ife_defines.svh"

module ife_fifo
(
    input  wire logic       core_clk, // core clock
    input  wire logic       rst,      // synchronous reset
    input  wire logic       push,     // write din
    input  wire logic [7:0] din,      // byte in
    input  wire logic       pop,      // drop head
    input  wire logic       flush,    // discard all
    output logic [7:0]      dout,     // head byte, from register
    output logic [2:0]      count,    // bytes held
    output logic            full,     // four bytes held
    output logic            empty     // nothing held
);
    ife_pkg::ife_fifo_t st;
    ife_pkg::ife_fifo_t next_st;
    logic               do_push;
    logic               do_pop;

    // =====================================================================
    // pointer and count update
    always_comb
    begin
        next_st = st;
        do_push = push && !full;
        do_pop  = pop && !empty;
        if (do_push)
        begin
            next_st.mem[st.wp] = din;
            next_st.wp         = st.wp + 2'h1;
        end
        if (do_pop)
            next_st.rp = st.rp + 2'h1;
        next_st.cnt = st.cnt + {2'h0, do_push} - {2'h0, do_pop};
        if (flush)
        begin
            next_st.wp  = 2'h0;
            next_st.rp  = 2'h0;
            next_st.cnt = 3'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign dout  = st.mem[st.rp];
    assign count = st.cnt;
    assign full  = (st.cnt == 3'(`IFE_FIFO_DEPTH));
    assign empty = (st.cnt == 3'h0);
endmodule

// ---- rtl/ife_tick.sv ----
`timescale 1ns/10ps
`include "ife_defines.svh"

module ife_tick
(
    input  wire logic       core_clk, // core clock
    input  wire logic       rst,      // synchronous reset
    input  wire logic       run,      // count while high
    input  wire logic [1:0] div,      // scl divider field
    output logic            tick      // one-cycle pulse per scl quarter
);
    ife_pkg::ife_tick_t st;
    ife_pkg::ife_tick_t next_st;
    logic [4:0]         limit;

    // =====================================================================
    // quarter period is (16 << div) / 4 core cycles
    always_comb
    begin
        limit   = 5'((`IFE_QTR_BASE << div) - 1);
        tick    = run && (st.cnt == limit);
        next_st = st;
        if (!run || tick)
            next_st.cnt = 5'h0;
        else
            next_st.cnt = st.cnt + 5'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

// ---- verif/ife_slv.sv ----
`timescale 1ns/10ps
// =====================================================================
// behavioural target on the wired-and bus
module ife_slv #(parameter logic [6:0] ADR = 7'h2C)
(
    input  wire logic scl,    // bus clock level
    input  wire logic sda,    // bus data level
    input  wire logic nak_wr, // refuse write data
    output logic      sda_oe  // pull sda low
);
    logic [7:0] sh, wq[$], rb;
    logic       fst, sel, rd, mack, skip, aq[$];
    int         bn = -1, rn, ns, np;
    initial {sda_oe, skip} = 2'b00;
    assign rb = 8'hC3 ^ rn[7:0];
    // start and stop framing, judged once scl has settled, so that an sda move
    // in the same step as a falling scl counts as data and not as framing
    always @(negedge sda)
    begin
        #1;
        if (scl && !sda) {bn, fst, sel, rn, ns, skip} = {32'd0, 2'b10, 32'd0, ns + 1, 1'b1};
    end
    always @(posedge sda)
    begin
        #1;
        if (scl && sda) {bn, np, sda_oe} = {-32'd1, np + 1, 1'b0};
    end
    // sample bits and the master acknowledge
    always @(posedge scl) if (bn >= 0 && bn < 8) sh = {sh[6:0], sda};
        else if (bn == 8) mack = !sda;
    // drive acknowledge and read data while scl is low; the fall that ends
    // the start condition precedes the first bit and is skipped
    always @(negedge scl) if (skip) skip = 0;
        else if (bn >= 0)
    begin
        sda_oe = 0;
        if (bn == 7 && fst) {sel, rd} = {sh[7:1] == ADR, sh[0]};
        if (bn == 7 && !fst && !rd && sel) wq.push_back(sh);
        if (bn == 7 && (fst || !rd)) sda_oe = sel && (fst || !nak_wr);
        if (bn == 8 && !fst && rd)
        begin
            aq.push_back(mack);
            rn++;
            sel = sel && mack;
        end
        if (bn == 8) {fst, bn} = {1'b0, 32'd0};
        else bn++;
        if (sel && rd && !fst && bn < 8) sda_oe = !rb[7 - bn];
    end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    // =====================================================================
    // clock, bus lines and bench state
    logic       core_clk = 0, rst = 1, wr = 0, rd = 0, te = 0, re = 0, rf = 0;
    logic [7:0] wa = 0, wd = 0, ra = 0, rdat, s, b, q[$];
    logic       scl_oe, sda_oe, s_oe, irq;
    wire        scl_w = !scl_oe;
    wire        sda_w = !(sda_oe | s_oe);
    int         err_count = 0, n_checks = 0, ns0, np0;
    always #2.5 core_clk = !core_clk;
    ife_engine i_dut (.core_clk(core_clk), .rst(rst), .sfr_wr(wr), .sfr_waddr(wa),
        .sfr_wdata(wd), .sfr_rd(rd), .sfr_raddr(ra), .sfr_rdata(rdat), .tx_irq_en(te),
        .rx_irq_en(re), .rx_irq_on_full(rf), .irq(irq), .scl_i(scl_w), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
    ife_slv i_slv (.scl(scl_w), .sda(sda_w), .nak_wr(1'b0), .sda_oe(s_oe));
    // =====================================================================
    // compare, register access and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) {wr, wa, wd} = {1'b1, a, d};
        @(negedge core_clk) wr = 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(negedge core_clk) {rd, ra} = {1'b1, a};
        @(negedge core_clk) rd = 0;
        s = rdat;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // poll status until the busy bit drops, bounded
    task automatic idle;
        int n;
        rdr(8'hEA);
        for (n = 0; n < 3000 && s[7] !== 1'b0; n++) rdr(8'hEA);
        if (n == 3000)
        begin
            chk(8'h00, 8'hFF);
            print_verdict;
        end
    endtask
    // =====================================================================
    // scenarios
    initial
    begin
        void'($urandom(82510));
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) {rst, te} = 2'b01;
        rdr(8'hEA);
        chk(s, 8'h10);
        chk({7'h0, irq}, 8'h01);
        rdr(8'h55);
        chk(s, 8'h00);
        te = 0;
        // preload, overfill, then write and underrun
        wrr(8'hE8, 8'h80);
        for (int i = 0; i < 5; i++)
        begin
            b = 8'($urandom);
            if (i < 4) q.push_back(b);
            wrr(8'h9A, b);
        end
        rdr(8'hEA);
        chk(s, 8'h0D);
        wrr(8'hEA, 8'h00);
        wrr(8'hE9, 8'h58);
        idle;
        chk(8'(i_slv.wq.size()), 8'd4);
        for (int i = 0; i < 4; i++) chk(i_slv.wq[i], q[i]);
        chk(s, 8'h10);
        $display("write test done");
        // read of three bytes with master acks and final nack
        wrr(8'hE8, 8'hA2);
        {re, rf} = 2'b11;
        wrr(8'hE9, 8'h59);
        idle;
        chk(s, 8'h38);
        chk({7'h0, irq}, 8'h00);
        rf = 0;
        #1 chk({7'h0, irq}, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            rdr(8'h9B);
            chk(s, 8'hC3 ^ 8'(k));
            chk({7'h0, i_slv.aq[k]}, 8'(k < 2));
        end
        chk(8'(i_slv.aq.size()), 8'd3);
        rdr(8'hEA);
        chk(s, 8'h10);
        $display("read test done");
        // clash, then missing acknowledge with a loaded fifo
        wrr(8'hE8, 8'h80);
        wrr(8'h9A, 8'h11);
        @(negedge core_clk) {wr, wa, wd, rd, ra} = {1'b1, 8'h9A, 8'h22, 1'b1, 8'h9B};
        @(negedge core_clk) {wr, rd} = 2'b00;
        rdr(8'hEA);
        chk(s, 8'h02);
        wrr(8'hE9, 8'h5A);
        idle;
        chk(s, 8'h52);
        wrr(8'hEA, 8'h00);
        rdr(8'hEA);
        chk(s, 8'h10);
        // disabled interface ignores an address write
        wrr(8'hE8, 8'h00);
        wrr(8'hE9, 8'h58);
        rdr(8'hEA);
        chk(s, 8'h10);
        $display("error test done");
        // address rewrite mid-transfer gives a repeated start
        wrr(8'hE8, 8'h80);
        {ns0, np0} = {i_slv.ns, i_slv.np};
        wrr(8'h9A, 8'h3C);
        wrr(8'hE9, 8'h58);
        repeat (40) @(negedge core_clk);
        wrr(8'hE9, 8'h59);
        idle;
        chk(8'(i_slv.ns - ns0), 8'd2);
        chk(8'(i_slv.np - np0), 8'd1);
        $display("restart test done");
        print_verdict;
    end
endmodule
